// ==== pkg/jtag_icache_consts.svh ====
`ifndef JTAG_ICACHE_CONSTS_SVH
`define JTAG_ICACHE_CONSTS_SVH

// ==========================================================
// Test port
`define CACHE_LOAD_OP   5'h07
`define IR_W            5
`define PKT_W           33
`define PKT_LAST_BIT    6'h20
`define BITCNT_W        6

// ==========================================================
// Cache functions
`define FN_W            3
`define FN_INV_LINE     3'h0
`define FN_INV_MINI     3'h1
`define FN_LOAD_MAIN    3'h2
`define FN_LOAD_MINI    3'h3

// ==========================================================
// Geometry
`define MAIN_KB_DEF     32
`define MINI_WAYS       2
`define MAIN_TO_MINI    16
`define LINE_BYTES      32
`define WORDS_PER_LINE  8
`define WORD_IDX_W      3
`define WORDS_LEFT_W    4
`define WORDS_FULL      4'h8
`define WORDS_ONE       4'h1
`define LINE_ADDR_W     27
`define VA_LINE_LSB     5
`define VA_WORD_LSB     2
`define VA_REMAP_LSB    25
`define REMAP_W         7

`endif

// ==== pkg/icache_load_pkg.sv ====
`include "jtag_icache_consts.svh"

package icache_load_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SHIFT  = 2'b01,
		ST_DECODE = 2'b10,
		ST_WRITE  = 2'b11
	} load_state_e;

	typedef struct packed {
		logic [`LINE_ADDR_W-1:0] line_addr;
		logic [2:0]              spare;
		logic [`FN_W-1:0]        func;
	} cmd_packet_s;

	typedef struct packed {
		logic        parity;
		logic [31:0] word;
	} data_packet_s;

	typedef struct packed {
		logic [`LINE_ADDR_W-1:0]       line_addr;
		logic [`WORDS_PER_LINE-1:0]    parity;
		logic [`WORDS_PER_LINE*32-1:0] words;
	} line_write_s;

endpackage

// ==== hw/bit_sync.sv ====
`timescale 1ns/100ps

module bit_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Level crossing
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

// ==== hw/jtag_icache_code_download.sv ====
`timescale 1ns/100ps
`include "jtag_icache_consts.svh"

module jtag_icache_code_download
	import icache_load_pkg::*;
#(
	parameter int MAIN_KB = `MAIN_KB_DEF
) (
	// Core clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	// Test access port, test clock domain
	input  wire logic                    tck,
	input  wire logic                    tap_reset_n,
	input  wire logic [`IR_W-1:0]        ir_value,
	input  wire logic                    capture_dr,
	input  wire logic                    shift_dr,
	input  wire logic                    update_dr,
	input  wire logic                    tdi,
	output logic                         tdo,
	// Core status
	input  wire logic                    core_reset,
	input  wire logic                    halt_mode,
	input  wire logic                    special_debug,
	input  wire logic [`REMAP_W-1:0]     process_id_remap,
	// Instruction fetch lookup
	input  wire logic                    fetch_valid,
	input  wire logic [31:0]             fetch_va,
	output logic                         fetch_hit,
	output logic [31:0]                  fetch_word,
	output logic                         fetch_parity,
	// System control coprocessor line invalidate
	input  wire logic                    cp_inv_line,
	input  wire logic [31:0]             cp_inv_va,
	// Main instruction cache side
	output logic                         main_load_valid,
	output line_write_s                  main_load_line,
	output logic                         main_inv_valid,
	output logic [`LINE_ADDR_W-1:0]      main_inv_line_addr,
	// Status
	output logic                         load_busy
);

	// ==========================================================
	// Geometry
	localparam int MINI_BYTES = MAIN_KB * 1024 / `MAIN_TO_MINI;
	localparam int WAYS       = `MINI_WAYS;
	localparam int SETS       = MINI_BYTES / (WAYS * `LINE_BYTES);
	localparam int IDX_W      = $clog2(SETS);
	localparam int WORDS      = `WORDS_PER_LINE;

	if (MAIN_KB != 32 && MAIN_KB != 16) begin : g_bad_size
		$error("MAIN_KB must be 16 or 32");
	end

	function automatic logic [IDX_W-1:0] set_of(input logic [`LINE_ADDR_W-1:0] la);
		return la[IDX_W-1:0];
	endfunction

	function automatic logic [1:0] way_match(
		input logic [`LINE_ADDR_W-1:0] la,
		input logic [`LINE_ADDR_W-1:0] tag0,
		input logic [`LINE_ADDR_W-1:0] tag1,
		input logic                    v0,
		input logic                    v1
	);
		return {v1 && tag1 == la, v0 && tag0 == la};
	endfunction

	// ==========================================================
	// Test clock side
	logic                   load_sel;
	logic                   load_q;
	logic [`PKT_W-1:0]      capture_shift_stage_q;
	logic [`PKT_W-1:0]      update_hold_stage_q;
	logic                   req_tgl_q;
	logic                   ack_tgl_q;
	logic                   ack_tck;
	logic                   hold_busy;

	assign load_sel  = (ir_value == `CACHE_LOAD_OP);
	assign hold_busy = req_tgl_q ^ ack_tck;
	assign tdo       = capture_shift_stage_q[0];

	always_ff @(posedge tck) begin
		if (!tap_reset_n) begin
			load_q <= 1'b0;
		end else begin
			load_q <= load_sel;
		end
	end

	// Capture leaves the stage as it was: its value is meaningless
	always_ff @(posedge tck) begin
		if (!tap_reset_n) begin
			capture_shift_stage_q <= '0;
		end else if (load_sel && shift_dr && !capture_dr) begin
			capture_shift_stage_q <= {tdi, capture_shift_stage_q[`PKT_W-1:1]};
		end
	end

	// Updates during a pending transfer are dropped to keep the word stable
	always_ff @(posedge tck) begin
		if (!tap_reset_n) begin
			update_hold_stage_q <= '0;
			req_tgl_q           <= 1'b0;
		end else if (load_sel && update_dr && !hold_busy) begin
			update_hold_stage_q <= capture_shift_stage_q;
			req_tgl_q           <= ~req_tgl_q;
		end
	end

	bit_sync #(
		.WIDTH (1)
	) u_ack_sync (
		.clk      (tck),
		.rst_n    (tap_reset_n),
		.async_in (ack_tgl_q),
		.sync_out (ack_tck)
	);

	// ==========================================================
	// Core clock side: crossing and load machine
	logic                       req_core;
	logic                       load_core;
	load_state_e                state_q;
	logic [`PKT_W-1:0]          core_side_shift_stage_q;
	logic [`PKT_W-1:0]          pkt_q;
	logic [`BITCNT_W-1:0]       bitcnt_q;
	logic [`WORDS_LEFT_W-1:0]   words_left_q;
	cmd_packet_s                cmd_q;
	cmd_packet_s                pkt_cmd;
	data_packet_s               line_buf_q [WORDS];
	logic                       new_pkt;
	logic                       dec_cmd;
	logic                       exec_inv_line;
	logic                       exec_inv_mini;
	logic                       exec_wr_main;
	logic                       exec_wr_mini;

	bit_sync #(
		.WIDTH (2)
	) u_req_sync (
		.clk      (ref_clk),
		.rst_n    (reset_n),
		.async_in ({req_tgl_q, load_q}),
		.sync_out ({req_core, load_core})
	);

	assign new_pkt       = (state_q == ST_IDLE) && (req_core != ack_tgl_q);
	assign pkt_cmd       = cmd_packet_s'(pkt_q);
	assign dec_cmd       = (state_q == ST_DECODE) && (words_left_q == '0);
	assign exec_inv_line = dec_cmd && pkt_cmd.func == `FN_INV_LINE;
	assign exec_inv_mini = dec_cmd && pkt_cmd.func == `FN_INV_MINI;
	assign exec_wr_main  = (state_q == ST_WRITE) && cmd_q.func == `FN_LOAD_MAIN;
	assign exec_wr_mini  = (state_q == ST_WRITE) && cmd_q.func == `FN_LOAD_MINI;
	assign load_busy     = (state_q != ST_IDLE) || (words_left_q != '0) || !load_core;

	// Acknowledge releases the hold stage once its copy is taken
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ack_tgl_q               <= 1'b0;
			core_side_shift_stage_q <= '0;
		end else if (new_pkt) begin
			ack_tgl_q               <= req_core;
			core_side_shift_stage_q <= update_hold_stage_q;
		end else if (state_q == ST_SHIFT) begin
			core_side_shift_stage_q <= core_side_shift_stage_q >> 1;
		end
	end

	// Runs on the block reset only, so core reset does not stall loading
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (new_pkt && load_core) begin
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (bitcnt_q == `PKT_LAST_BIT) begin
						state_q <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					if (words_left_q == `WORDS_ONE) begin
						state_q <= ST_WRITE;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				ST_WRITE: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			bitcnt_q <= '0;
			pkt_q    <= '0;
		end else if (state_q == ST_SHIFT) begin
			bitcnt_q <= bitcnt_q + 1'b1;
			pkt_q    <= {core_side_shift_stage_q[0], pkt_q[`PKT_W-1:1]};
		end else begin
			bitcnt_q <= '0;
		end
	end

	// Dropping the instruction abandons a partly gathered line
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			words_left_q <= '0;
			cmd_q        <= '0;
		end else if (!load_core) begin
			words_left_q <= '0;
		end else if (state_q == ST_DECODE) begin
			if (words_left_q != '0) begin
				words_left_q <= words_left_q - 1'b1;
			end else if (pkt_cmd.func == `FN_LOAD_MAIN || pkt_cmd.func == `FN_LOAD_MINI) begin
				cmd_q        <= pkt_cmd;
				words_left_q <= `WORDS_FULL;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (state_q == ST_DECODE && words_left_q != '0) begin
			line_buf_q[`WORD_IDX_W'(`WORDS_FULL - words_left_q)] <= data_packet_s'(pkt_q);
		end
	end

	// ==========================================================
	// Main cache requests
	line_write_s line_pack;

	always_comb begin
		line_pack           = '0;
		line_pack.line_addr = cmd_q.line_addr;
		for (int w = 0; w < WORDS; w++) begin
			line_pack.words[w*32 +: 32] = line_buf_q[w].word;
			line_pack.parity[w]         = line_buf_q[w].parity;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			main_load_valid    <= 1'b0;
			main_load_line     <= '0;
			main_inv_valid     <= 1'b0;
			main_inv_line_addr <= '0;
		end else begin
			main_load_valid <= exec_wr_main;
			main_inv_valid  <= exec_inv_line;
			if (exec_wr_main) begin
				main_load_line <= line_pack;
			end
			if (exec_inv_line) begin
				main_inv_line_addr <= pkt_cmd.line_addr;
			end
		end
	end

	// ==========================================================
	// Small cache, storage of its own
	logic [`LINE_ADDR_W-1:0] tag_q   [WAYS][SETS];
	logic [`PKT_W-1:0]       data_q  [WAYS][SETS][WORDS];
	logic [SETS-1:0]         valid_q [WAYS];
	logic [SETS-1:0]         rr_q;
	logic [IDX_W-1:0]        wr_set;
	logic [1:0]              wr_match;
	logic                    wr_way;
	logic [IDX_W-1:0]        cp_set;
	logic [1:0]              cp_match;
	logic [IDX_W-1:0]        inv_set;
	logic [1:0]              inv_match;
	logic [`LINE_ADDR_W-1:0] cp_la;

	assign cp_la     = cp_inv_va[31:`VA_LINE_LSB];
	assign wr_set    = set_of(cmd_q.line_addr);
	assign cp_set    = set_of(cp_la);
	assign inv_set   = set_of(pkt_cmd.line_addr);
	assign wr_match  = way_match(cmd_q.line_addr, tag_q[0][wr_set], tag_q[1][wr_set],
		valid_q[0][wr_set], valid_q[1][wr_set]);
	assign cp_match  = way_match(cp_la, tag_q[0][cp_set], tag_q[1][cp_set],
		valid_q[0][cp_set], valid_q[1][cp_set]);
	assign inv_match = way_match(pkt_cmd.line_addr, tag_q[0][inv_set], tag_q[1][inv_set],
		valid_q[0][inv_set], valid_q[1][inv_set]);
	// Reloading a resident line reuses its way to avoid duplicates
	assign wr_way    = (|wr_match) ? wr_match[1] : rr_q[wr_set];

	// Only the test port fills lines; fetch misses never allocate here
	always_ff @(posedge ref_clk) begin
		if (exec_wr_mini) begin
			tag_q[wr_way][wr_set] <= cmd_q.line_addr;
			for (int w = 0; w < WORDS; w++) begin
				data_q[wr_way][wr_set][w] <= line_buf_q[w];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rr_q <= '0;
		end else if (exec_wr_mini && !(|wr_match)) begin
			rr_q[wr_set] <= ~rr_q[wr_set];
		end
	end

	// Global coprocessor invalidate is deliberately not wired in here
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < WAYS; i++) begin
				valid_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < WAYS; i++) begin
				if (exec_inv_mini || (core_reset && !halt_mode && !load_core)) begin
					valid_q[i] <= '0;
				end
				if (cp_inv_line && cp_match[i]) begin
					valid_q[i][cp_set] <= 1'b0;
				end
				if (exec_inv_line && inv_match[i]) begin
					valid_q[i][inv_set] <= 1'b0;
				end
			end
			if (exec_wr_mini) begin
				valid_q[wr_way][wr_set] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Fetch lookup
	logic [31:0]             look_va;
	logic [`LINE_ADDR_W-1:0] look_la;
	logic [IDX_W-1:0]        look_set;
	logic [1:0]              look_match;
	logic [`PKT_W-1:0]       look_data;

	// Debug handler runs untranslated, so remap is skipped there
	always_comb begin
		look_va = fetch_va;
		if (!special_debug && fetch_va[31:`VA_REMAP_LSB] == '0) begin
			look_va[31:`VA_REMAP_LSB] = process_id_remap;
		end
	end

	assign look_la    = look_va[31:`VA_LINE_LSB];
	assign look_set   = set_of(look_la);
	assign look_match = way_match(look_la, tag_q[0][look_set], tag_q[1][look_set],
		valid_q[0][look_set], valid_q[1][look_set]);
	assign look_data  = data_q[look_match[1]][look_set]
		[look_va[`VA_LINE_LSB-1:`VA_WORD_LSB]];

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			fetch_hit    <= 1'b0;
			fetch_word   <= '0;
			fetch_parity <= 1'b0;
		end else begin
			fetch_hit <= fetch_valid && (|look_match);
			if (fetch_valid) begin
				fetch_word   <= look_data[31:0];
				fetch_parity <= look_data[`PKT_W-1];
			end
		end
	end

endmodule

// ==== dv/jtag_icache_checker.sv ====
`timescale 1ns/100ps
`include "jtag_icache_consts.svh"

module jtag_icache_checker
	import icache_load_pkg::*;
#(
	parameter int MAIN_KB = `MAIN_KB_DEF
) (
	// Clocks and resets
	input wire logic             ref_clk,
	input wire logic             reset_n,
	input wire logic             tck,
	input wire logic             tap_reset_n,
	// Test port and core side
	input wire logic [`IR_W-1:0] ir_value,
	input wire logic             shift_dr,
	input wire logic             tdo,
	input wire logic             core_reset,
	input wire logic             halt_mode,
	input wire logic             fetch_valid,
	input wire logic [31:0]      fetch_va,
	input wire logic             fetch_hit,
	input wire logic             cp_inv_line,
	input wire logic [31:0]      cp_inv_va,
	input wire logic             main_load_valid,
	input wire logic             main_inv_valid,
	input wire logic             load_busy
);
	// ==========================================================
	// Sequences
	sequence s_plain_reset;
		core_reset && !halt_mode && ir_value != `CACHE_LOAD_OP;
	endsequence
	// Top bits nonzero so the lookup cannot be remapped
	sequence s_cp_then_fetch;
		cp_inv_line ##2 (fetch_valid && fetch_va[31:25] != 7'h00
			&& fetch_va[31:5] == $past(cp_inv_va[31:5], 2));
	endsequence

	// ==========================================================
	// Core domain
	a_hit_needs_fetch: assert property (@(posedge ref_clk) disable iff (!reset_n)
		fetch_hit |-> $past(fetch_valid)) else $error("hit without lookup");
	a_load_one_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
		main_load_valid |=> !main_load_valid) else $error("line write pulse too long");
	a_inv_one_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
		main_inv_valid |=> !main_inv_valid) else $error("invalidate pulse too long");
	a_busy_no_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(ir_value != `CACHE_LOAD_OP) [*4] |-> load_busy) else $error("idle without instruction");
	a_out_after_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(main_load_valid || main_inv_valid) |-> $past(load_busy)) else $error("output unprompted");
	a_reset_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_plain_reset [*4] ##0 fetch_valid |=> !fetch_hit) else $error("hit in core reset");
	a_cp_inv_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_cp_then_fetch |=> !fetch_hit) else $error("hit after line invalidate");

	// ==========================================================
	// Test clock domain
	a_tdo_hold: assert property (@(posedge tck) disable iff (!tap_reset_n)
		!(shift_dr && ir_value == `CACHE_LOAD_OP) |=> $stable(tdo)) else $error("tdo moved");
endmodule

bind jtag_icache_code_download jtag_icache_checker #(.MAIN_KB(MAIN_KB)) u_checker (
	.ref_clk(ref_clk), .reset_n(reset_n), .tck(tck), .tap_reset_n(tap_reset_n),
	.ir_value(ir_value), .shift_dr(shift_dr), .tdo(tdo), .core_reset(core_reset),
	.halt_mode(halt_mode), .fetch_valid(fetch_valid), .fetch_va(fetch_va),
	.fetch_hit(fetch_hit), .cp_inv_line(cp_inv_line), .cp_inv_va(cp_inv_va),
	.main_load_valid(main_load_valid), .main_inv_valid(main_inv_valid), .load_busy(load_busy)
);

// ==== dv/jtag_host_model.sv ====
`timescale 1ns/100ps
`include "jtag_icache_consts.svh"

module jtag_host_model (
	// Test port toward the device
	output logic             tck,
	output logic             tap_reset_n,
	output logic [`IR_W-1:0] ir_value,
	output logic             capture_dr,
	output logic             shift_dr,
	output logic             update_dr,
	output logic             tdi
);
	initial begin
		tck = 1'b0;
		tap_reset_n = 1'b0;
		ir_value = 5'h01;
		capture_dr = 1'b0;
		shift_dr = 1'b0;
		update_dr = 1'b0;
		tdi = 1'b0;
	end

	// Test clock only runs inside tasks; it stands still between frames
	task automatic ticks(input int n);
		repeat (n) begin
			#40 tck = 1'b1;
			#40 tck = 1'b0;
		end
	endtask

	task automatic reset_tap();
		#7 ticks(4);
		tap_reset_n = 1'b1;
	endtask

	task automatic set_ir(input logic [`IR_W-1:0] code);
		ir_value = code;
		ticks(2);
	endtask

	// Idle clocks after the update let the acknowledge return; an early update is dropped
	task automatic send(input logic [`PKT_W-1:0] pkt);
		capture_dr = 1'b1;
		ticks(1);
		capture_dr = 1'b0;
		shift_dr = 1'b1;
		for (int i = 0; i < `PKT_W; i++) begin
			tdi = pkt[i];
			ticks(1);
		end
		shift_dr = 1'b0;
		tdi = ~tdi;
		update_dr = 1'b1;
		ticks(1);
		update_dr = 1'b0;
		ticks(4);
	endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`include "jtag_icache_consts.svh"

module tb;
	import icache_load_pkg::*;

	logic ref_clk, reset_n, tck, tap_reset_n, capture_dr, shift_dr, update_dr, tdi, tdo;
	logic core_reset, halt_mode, special_debug, fetch_valid, fetch_hit, fetch_parity;
	logic cp_inv_line, main_load_valid, main_inv_valid, load_busy;
	logic [`IR_W-1:0] ir_value;
	logic [`REMAP_W-1:0] process_id_remap;
	logic [31:0] fetch_va, fetch_word, cp_inv_va;
	logic [`LINE_ADDR_W-1:0] main_inv_line_addr, seen_inv;
	line_write_s main_load_line, seen_line;
	logic [31:0] words [8];
	int failures = 0, compares = 0, cycles = 0, loads_seen = 0, invs_seen = 0;

	jtag_icache_code_download #(.MAIN_KB(32)) DUT (
		.ref_clk(ref_clk), .reset_n(reset_n), .tck(tck), .tap_reset_n(tap_reset_n),
		.ir_value(ir_value), .capture_dr(capture_dr), .shift_dr(shift_dr),
		.update_dr(update_dr), .tdi(tdi), .tdo(tdo), .core_reset(core_reset),
		.halt_mode(halt_mode), .special_debug(special_debug),
		.process_id_remap(process_id_remap), .fetch_valid(fetch_valid), .fetch_va(fetch_va),
		.fetch_hit(fetch_hit), .fetch_word(fetch_word), .fetch_parity(fetch_parity),
		.cp_inv_line(cp_inv_line), .cp_inv_va(cp_inv_va), .main_load_valid(main_load_valid),
		.main_load_line(main_load_line), .main_inv_valid(main_inv_valid),
		.main_inv_line_addr(main_inv_line_addr), .load_busy(load_busy)
	);

	jtag_host_model host (
		.tck(tck), .tap_reset_n(tap_reset_n), .ir_value(ir_value), .capture_dr(capture_dr),
		.shift_dr(shift_dr), .update_dr(update_dr), .tdi(tdi)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Output pulses are caught here, the run is bounded here
	always @(posedge ref_clk) begin
		cycles++;
		if (main_load_valid === 1'b1) begin
			seen_line = main_load_line;
			loads_seen++;
		end
		if (main_inv_valid === 1'b1) begin
			seen_inv = main_inv_line_addr;
			invs_seen++;
		end
		if (cycles == 60000) begin
			failures++;
			finish_test();
		end
	end

	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp, input string what);
		chk_val({63'h0, got}, {63'h0, exp}, what);
	endtask

	task automatic finish_test();
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (load_busy !== 1'b0 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		chk_flag(load_busy, 1'b0, "busy after function");
	endtask

	// Command packet, data packets for the two load functions only
	task automatic run_fn(input logic [2:0] fn, input logic [31:0] va);
		host.send({va[31:5], 3'h0, fn});
		if (fn[2:1] == 2'b01) begin
			for (int i = 0; i < 8; i++) begin
				words[i] = $urandom();
				host.send({^words[i], words[i]});
			end
		end
		host.ticks(30);
		wait_idle();
	endtask

	task automatic fetch(input logic [31:0] va, input logic hit, input logic [31:0] w);
		@(posedge ref_clk);
		fetch_valid <= 1'b1;
		fetch_va <= va;
		@(posedge ref_clk);
		fetch_valid <= 1'b0;
		#1;
		chk_flag(fetch_hit, hit, "hit");
		if (hit) begin
			chk_val(fetch_word, w, "word");
			chk_flag(fetch_parity, ^w, "parity");
		end
	endtask

	task automatic check_line(input logic [31:0] va);
		for (int i = 0; i < 8; i++) begin
			fetch({va[31:5], 3'(i), 2'h0}, 1'b1, words[i]);
		end
	endtask

	initial begin
		logic [31:0] a, b, c, d, e;
		logic [31:0] kept [8];
		int n;
		reset_n = 1'b0;
		core_reset = 1'b0;
		halt_mode = 1'b0;
		special_debug = 1'b1;
		process_id_remap = 7'h00;
		fetch_valid = 1'b0;
		fetch_va = 32'h0;
		cp_inv_line = 1'b0;
		cp_inv_va = 32'h0;
		void'($urandom(3336));
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		host.reset_tap();
		chk_flag(load_busy, 1'b1, "busy without instruction");
		host.set_ir(`CACHE_LOAD_OP);
		// Word index zero so single fetches expect word 0 of the line
		a = ($urandom() | 32'h0200_0000) & 32'hFFFF_FFE0;
		b = $urandom() | 32'h0200_0000;
		n = loads_seen;
		run_fn(3'h2, b);
		chk_val(loads_seen, n + 1, "main writes");
		chk_val(seen_line.line_addr, b[31:5], "main line");
		for (int i = 0; i < 8; i++) begin
			chk_val(seen_line.words[i*32+:32], words[i], "main word");
			chk_flag(seen_line.parity[i], ^words[i], "main parity");
		end
		fetch(b, 1'b0, 32'h0);
		fetch(a, 1'b0, 32'h0);
		fetch(a, 1'b0, 32'h0);
		run_fn(3'h3, a);
		check_line(a);
		b = a ^ 32'h0000_0400;
		c = a ^ 32'h0000_0800;
		run_fn(3'h3, b);
		kept = words;
		run_fn(3'h3, c);
		check_line(c);
		fetch(a, 1'b0, 32'h0);
		fetch(b, 1'b1, kept[0]);
		run_fn(3'h3, c);
		check_line(c);
		fetch(b, 1'b1, kept[0]);
		@(posedge ref_clk);
		cp_inv_line <= 1'b1;
		cp_inv_va <= c;
		@(posedge ref_clk);
		cp_inv_line <= 1'b0;
		fetch(c, 1'b0, 32'h0);
		fetch(b, 1'b1, kept[0]);
		n = invs_seen;
		run_fn(3'h0, b);
		fetch(b, 1'b0, 32'h0);
		chk_val(invs_seen, n + 1, "invalidate pulses");
		chk_val(seen_inv, b[31:5], "invalidate line");
		d = {7'h35, 20'($urandom()), 5'h00};
		run_fn(3'h3, d);
		kept = words;
		@(posedge ref_clk);
		special_debug <= 1'b0;
		process_id_remap <= 7'h35;
		fetch({7'h00, d[24:0]}, 1'b1, kept[0]);
		@(posedge ref_clk);
		special_debug <= 1'b1;
		fetch({7'h00, d[24:0]}, 1'b0, 32'h0);
		for (int f = 4; f < 8; f++) begin
			run_fn(3'(f), d);
		end
		fetch(d, 1'b1, kept[0]);
		host.set_ir(5'h01);
		host.send({27'h0, 3'h0, `FN_INV_MINI});
		host.set_ir(`CACHE_LOAD_OP);
		wait_idle();
		fetch(d, 1'b1, kept[0]);
		run_fn(`FN_INV_MINI, 32'h0);
		fetch(d, 1'b0, 32'h0);
		e = ($urandom() | 32'h0200_0000) & 32'hFFFF_FFE0;
		@(posedge ref_clk);
		core_reset <= 1'b1;
		run_fn(3'h3, e);
		fetch(e, 1'b1, words[0]);
		@(posedge ref_clk);
		halt_mode <= 1'b1;
		host.set_ir(5'h01);
		repeat (4) @(posedge ref_clk);
		fetch(e, 1'b1, words[0]);
		@(posedge ref_clk);
		halt_mode <= 1'b0;
		repeat (4) @(posedge ref_clk);
		fetch(e, 1'b0, 32'h0);
		core_reset <= 1'b0;
		finish_test();
	end
endmodule
